/* File: phd_consts.svh */
// Constants for the preload hint decoder: opcode patterns, field positions,
// register numbers and reset values. Included by the decoder module only.
`ifndef PHD_CONSTS_SVH
`define PHD_CONSTS_SVH

// First halfword patterns, compared against instruction bits [31:20]
`define PHD_PLD_REG_HW1   12'hF81
`define PHD_PLI_POS_HW1   12'hF99
`define PHD_PLI_NEG_HW1   12'hF91
// Literal instruction preload: bits [31:24] and bits [22:16]
`define PHD_PLI_LIT_HI    8'hF9
`define PHD_PLI_LIT_LO    7'h1F
// Second halfword patterns
`define PHD_PLD_REG_HW2   10'h3C0
`define PHD_PLI_NEG_HW2   8'hFC
`define PHD_LONG_IMMEDIATE_FIELD_HW2     4'hF

// Field positions inside the 32-bit instruction word (first halfword high)
`define PHD_BASE_MSB      19
`define PHD_BASE_LSB      16
`define PHD_DIR_BIT       23
`define PHD_SHIFT_MSB     5
`define PHD_SHIFT_LSB     4
`define PHD_OFFS_MSB      3
`define PHD_OFFS_LSB      0
`define PHD_LONG_IMMEDIATE_FIELD_MSB     11
`define PHD_SHORT_IMMEDIATE_FIELD_MSB      7

// Register numbers
`define PHD_REG_PC        4'hF
`define PHD_REG_SP        4'hD

// Address forming
`define PHD_PC_ALIGN_MASK 32'hFFFF_FFFC
`define PHD_ADDR_RESET    32'h0000_0000
`define PHD_IDX_RESET     4'h0

`endif

/* File: phd_pkg.sv */
// Types shared by the preload hint decoder modules.
// Assumes phd_consts.svh is on the include path.
package phd_pkg;

	// Decoded preload form carried down the pipe
	typedef enum logic [2:0] {
		PHD_OP_NONE,
		PHD_OP_PLD_REG,
		PHD_OP_PLI_POS,
		PHD_OP_PLI_NEG,
		PHD_OP_PLI_LIT
	} phd_op_t;

endpackage : phd_pkg

/* File: phd_addr_unit.sv */
// Effective address adder for the preload hint decoder.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module phd_addr_unit #(
	parameter int ADDR_W = 32
) (
	input  wire logic [ADDR_W-1:0] base_value,
	input  wire logic [ADDR_W-1:0] offset_value,
	input  wire logic [1:0]        shift_amount,
	input  wire logic              add_sel,
	output logic      [ADDR_W-1:0] eff_addr
);

	logic [ADDR_W-1:0] shifted;

	// Logical left shift, then add or subtract; carries out are dropped
	always_comb begin
		shifted  = offset_value << shift_amount;
		eff_addr = add_sel ? (base_value + shifted) : (base_value - shifted);
	end

endmodule : phd_addr_unit

/* File: phd_preload_hint_decoder.sv */
// Preload hint decoder: register-offset data preload and immediate/literal
// instruction preload. Two-stage pipe, one instruction per clock.
// Assumes a register file with combinational read on the same clock, and a
// cache hint port that takes one-cycle request pulses without back-pressure.
//
// Operation
// - Data preload base all ones goes literal
// - Offset register 13 or 15 flagged unpredictable
// - Offset shifted left by zero to three
// - Data address is base plus shifted offset
// - Stack pointer accepted as base register
// - Positive form zero-extends twelve-bit immediate, adds
// - Base all ones redirects to literal form
// - Negative form zero-extends eight-bit immediate, subtracts
// - Literal form: base 15, direction bit
// - Program counter base aligned down to four
// - Passing condition issues instruction preload hint
// - Offset range follows immediate field widths
// - Plus zero and minus zero both accepted
// - Instruction hint changes no architectural state
// - Data hint is only a speed hint
`timescale 1ns/1ps
`include "phd_consts.svh"

module phd_preload_hint_decoder #(
	parameter int ADDR_W = 32
) (
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              instr_valid,
	input  wire logic [31:0]       instr_word,
	input  wire logic              cond_pass,
	input  wire logic [ADDR_W-1:0] pc_value,
	input  wire logic [ADDR_W-1:0] base_rdata,
	input  wire logic [ADDR_W-1:0] offset_rdata,
	output logic      [3:0]        base_reg_field,
	output logic      [3:0]        offset_reg_field,
	output logic                   data_prefetch_request,
	output logic                   instr_prefetch_request,
	output logic      [ADDR_W-1:0] prefetch_addr,
	output logic                   unpredictable_flag,
	output logic                   literal_data_redirect
);
	import phd_pkg::*;

	// Stage one state
	phd_op_t           op_reg,       op_next;
	logic              cond_reg,     cond_next;
	logic              redir1_reg,   redir1_next;
	logic [3:0]        base_idx_reg, base_idx_next;
	logic [3:0]        offs_idx_reg, offs_idx_next;
	logic [1:0]        shift_reg,    shift_next;
	logic [11:0]       imm_reg,      imm_next;
	logic              add_reg,      add_next;
	logic [ADDR_W-1:0] pc_reg,       pc_next;

	// Stage two state (module outputs)
	logic              dreq_reg,     dreq_next;
	logic              ireq_reg,     ireq_next;
	logic [ADDR_W-1:0] addr_reg,     addr_next;
	logic              unpred_reg,   unpred_next;
	logic              redir2_reg,   redir2_next;

	// Instruction fields
	logic [3:0]  fld_base;
	logic [1:0]  shift_amount_field;
	logic [11:0] long_immediate_field;
	logic [7:0]  short_immediate_field;
	logic        is_lit, is_pos, is_neg, is_pld;

	// Address unit operands
	logic [ADDR_W-1:0] base_val, offs_val, eff_addr;
	logic [1:0]        shift_sel;
	logic              unpred_now;

	always_comb begin
		fld_base              = instr_word[`PHD_BASE_MSB:`PHD_BASE_LSB];
		shift_amount_field    = instr_word[`PHD_SHIFT_MSB:`PHD_SHIFT_LSB];
		long_immediate_field  = instr_word[`PHD_LONG_IMMEDIATE_FIELD_MSB:0];
		short_immediate_field = instr_word[`PHD_SHORT_IMMEDIATE_FIELD_MSB:0];
	end

	// direction bit free, so both zeros
	always_comb begin
		is_lit = (instr_word[31:24] == `PHD_PLI_LIT_HI)
			&& (instr_word[22:16] == `PHD_PLI_LIT_LO)
			&& (instr_word[15:12] == `PHD_LONG_IMMEDIATE_FIELD_HW2);
		is_pos = (instr_word[31:20] == `PHD_PLI_POS_HW1)
			&& (instr_word[15:12] == `PHD_LONG_IMMEDIATE_FIELD_HW2);
		is_neg = (instr_word[31:20] == `PHD_PLI_NEG_HW1)
			&& (instr_word[15:8] == `PHD_PLI_NEG_HW2);
		is_pld = (instr_word[31:20] == `PHD_PLD_REG_HW1)
			&& (instr_word[15:6] == `PHD_PLD_REG_HW2);
	end

	// Stage one decode; literal checked first so base of all ones lands there
	always_comb begin
		op_next       = PHD_OP_NONE;
		redir1_next   = 1'b0;
		cond_next     = cond_pass;
		pc_next       = pc_value;
		base_idx_next = fld_base;
		offs_idx_next = `PHD_IDX_RESET;
		shift_next    = 2'h0;
		imm_next      = 12'h000;
		add_next      = 1'b1;
		if (instr_valid) begin
			if (is_lit) begin
				op_next       = PHD_OP_PLI_LIT;
				base_idx_next = `PHD_REG_PC;
				imm_next      = long_immediate_field;
				add_next      = instr_word[`PHD_DIR_BIT];
			end else if (is_pos) begin
				op_next  = PHD_OP_PLI_POS;
				imm_next = long_immediate_field;
			end else if (is_neg) begin
				op_next  = PHD_OP_PLI_NEG;
				imm_next = {4'h0, short_immediate_field};
				add_next = 1'b0;
			end else if (is_pld) begin
				if (fld_base == `PHD_REG_PC) begin
					redir1_next = 1'b1;
				end else begin
					op_next       = PHD_OP_PLD_REG;
					offs_idx_next = instr_word[`PHD_OFFS_MSB:`PHD_OFFS_LSB];
					shift_next    = shift_amount_field;
				end
			end
		end
	end

	// Stage one registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			op_reg       <= PHD_OP_NONE;
			cond_reg     <= 1'b0;
			redir1_reg   <= 1'b0;
			base_idx_reg <= `PHD_IDX_RESET;
			offs_idx_reg <= `PHD_IDX_RESET;
			shift_reg    <= 2'h0;
			imm_reg      <= 12'h000;
			add_reg      <= 1'b1;
			pc_reg       <= `PHD_ADDR_RESET;
		end else begin
			op_reg       <= op_next;
			cond_reg     <= cond_next;
			redir1_reg   <= redir1_next;
			base_idx_reg <= base_idx_next;
			offs_idx_reg <= offs_idx_next;
			shift_reg    <= shift_next;
			imm_reg      <= imm_next;
			add_reg      <= add_next;
			pc_reg       <= pc_next;
		end
	end

	// Operand selection for the address unit
	always_comb begin
		if (base_idx_reg == `PHD_REG_PC) begin
			base_val = pc_reg & `PHD_PC_ALIGN_MASK;
		end else begin
			base_val = base_rdata;
		end
		if (op_reg == PHD_OP_PLD_REG) begin
			offs_val  = offset_rdata;
			shift_sel = shift_reg;
		end else begin
			offs_val  = {{(ADDR_W-12){1'b0}}, imm_reg};
			shift_sel = 2'h0;
		end
		unpred_now = (op_reg == PHD_OP_PLD_REG)
			&& ((offs_idx_reg == `PHD_REG_SP) || (offs_idx_reg == `PHD_REG_PC));
	end

	phd_addr_unit #(
		.ADDR_W(ADDR_W)
	) u_addr (
		.base_value  (base_val),
		.offset_value(offs_val),
		.shift_amount(shift_sel),
		.add_sel     (add_reg),
		.eff_addr    (eff_addr)
	);

	// Stage two: hints only when the condition passes; undefined ones issue none
	always_comb begin
		addr_next   = addr_reg;
		redir2_next = redir1_reg;
		unpred_next = cond_reg && unpred_now;
		dreq_next   = cond_reg && !unpred_now && (op_reg == PHD_OP_PLD_REG);
		ireq_next   = cond_reg && ((op_reg == PHD_OP_PLI_POS)
			|| (op_reg == PHD_OP_PLI_NEG) || (op_reg == PHD_OP_PLI_LIT));
		if (dreq_next || ireq_next) begin
			addr_next = eff_addr;
		end
	end

	// Stage two registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dreq_reg   <= 1'b0;
			ireq_reg   <= 1'b0;
			addr_reg   <= `PHD_ADDR_RESET;
			unpred_reg <= 1'b0;
			redir2_reg <= 1'b0;
		end else begin
			dreq_reg   <= dreq_next;
			ireq_reg   <= ireq_next;
			addr_reg   <= addr_next;
			unpred_reg <= unpred_next;
			redir2_reg <= redir2_next;
		end
	end

	// Outputs straight from flip-flops
	assign base_reg_field         = base_idx_reg;
	assign offset_reg_field       = offs_idx_reg;
	assign data_prefetch_request  = dreq_reg;
	assign instr_prefetch_request = ireq_reg;
	assign prefetch_addr          = addr_reg;
	assign unpredictable_flag     = unpred_reg;
	assign literal_data_redirect  = redir2_reg;

endmodule : phd_preload_hint_decoder

/* File: phd_properties.sv */
// Port checker for the preload hint decoder.
// Bound to the decoder top; single clock domain.
`timescale 1ns/1ps
module phd_properties (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        instr_valid,
	input wire logic [31:0] instr_word,
	input wire logic        cond_pass,
	input wire logic [31:0] base_rdata,
	input wire logic [31:0] offset_rdata,
	input wire logic        data_prefetch_request,
	input wire logic        instr_prefetch_request,
	input wire logic [31:0] prefetch_addr,
	input wire logic        unpredictable_flag,
	input wire logic        literal_data_redirect
);
	// Form matches; an all-ones base leaves these forms
	wire [31:0] w = instr_word;
	wire        r = instr_valid && w[31:20] == 12'hF81 && w[15:6] == 10'h3C0;
	wire        d = r && cond_pass && w[19:16] != 4'hF;
	wire        u = w[3:0] == 4'hD || w[3:0] == 4'hF;
	wire        p = instr_valid && cond_pass && w[31:20] == 12'hF99 && w[15:12] == 4'hF;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// Instruction hint two cycles after the take
	sequence s_ih;
		##2 instr_prefetch_request;
	endsequence
	AST_PLD: assert property (d && !u |-> ##2 data_prefetch_request) else $error("pld");
	AST_ADDR: assert property (d && !u |-> ##2 prefetch_addr ==
		$past(base_rdata) + ($past(offset_rdata) << $past(w[5:4], 2))) else $error("addr");
	AST_ODD: assert property (d && u |-> ##2 unpredictable_flag && !data_prefetch_request)
		else $error("odd");
	AST_REDIR: assert property (r && &w[19:16] |-> ##2 literal_data_redirect)
		else $error("redirect");
	AST_POS: assert property (p && w[19:16] != 4'hF |-> s_ih ##0 prefetch_addr ==
		$past(base_rdata) + $past(w[11:0], 2)) else $error("pos");
	AST_IDLE: assert property (instr_valid && !cond_pass |-> ##2 !data_prefetch_request &&
		!instr_prefetch_request) else $error("idle");
	AST_HOLD: assert property (!data_prefetch_request && !instr_prefetch_request |->
		$stable(prefetch_addr)) else $error("hold");
	AST_EXCL: assert property (!(data_prefetch_request && instr_prefetch_request))
		else $error("both");
endmodule : phd_properties
bind phd_preload_hint_decoder phd_properties u_props (.clock, .rstn, .instr_valid, .instr_word,
	.cond_pass, .base_rdata, .offset_rdata, .data_prefetch_request, .instr_prefetch_request,
	.prefetch_addr, .unpredictable_flag, .literal_data_redirect);

/* File: phd_hint_sink.sv */
// Cache hint port model; it only counts hints.
// Assumes one-cycle pulses and no back-pressure.
`timescale 1ns/1ps
module phd_hint_sink (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        data_prefetch_request,
	input  wire logic        instr_prefetch_request,
	output logic      [15:0] hint_count
);
	// counted, nothing else changes; reset keeps one driver
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			hint_count <= 16'h0000;
		else
			hint_count <= hint_count + 16'(data_prefetch_request) + 16'(instr_prefetch_request);
	end
endmodule : phd_hint_sink

/* File: tb.sv */
// Queue-model bench for the preload hint decoder.
// Assumes the checker binds itself to the decoder.
`timescale 1ns/1ps
module tb;
	typedef struct {logic d, i, u, r, m; logic [7:0] f; logic [31:0] a;} phd_exp_t;
	logic        clock = 0, rstn = 0, instr_valid = 0, cond_pass = 0;
	logic [31:0] instr_word = 0, pc_value = 0, last = 0, seed = 32'h0000_A485;
	logic [31:0] base_rdata, offset_rdata, prefetch_addr, rf [16];
	logic [31:0] dir [8] = '{32'hF992_F010, 32'hF811_F023, 32'hF81F_F000, 32'hF811_F00D,
		32'hF81D_F002, 32'hF99F_F000, 32'hF91F_F000, 32'hF913_FCFF};
	logic [15:0] hint_count;
	logic [3:0]  base_reg_field, offset_reg_field;
	logic        data_prefetch_request, instr_prefetch_request;
	logic        unpredictable_flag, literal_data_redirect;
	phd_exp_t    q [$];
	int          err_count = 0, check_count = 0, hints = 0;
	// Register file reads are combinational
	assign base_rdata = rf[base_reg_field];
	assign offset_rdata = rf[offset_reg_field];
	always #50 clock = ~clock;
	phd_preload_hint_decoder u_dut (.clock, .rstn, .instr_valid, .instr_word, .cond_pass,
		.pc_value, .base_rdata, .offset_rdata, .base_reg_field, .offset_reg_field,
		.data_prefetch_request, .instr_prefetch_request, .prefetch_addr, .unpredictable_flag,
		.literal_data_redirect);
	phd_hint_sink u_sink (.clock, .rstn, .data_prefetch_request, .instr_prefetch_request,
		.hint_count);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Expected outcome of one word; fields only checked when m
	function automatic phd_exp_t model(logic [31:0] w, logic c, logic [31:0] p);
		phd_exp_t e;
		logic [31:0] b;
		e = '{default: 0};
		b = rf[w[19:16]];
		e.f = {w[19:16], 4'h0};
		p = p & 32'hFFFF_FFFC;
		if (w[31:20] == 12'hF81 && w[15:6] == 10'h3C0) begin
			e.r = &w[19:16];
			e.m = !e.r;
			e.f = {w[19:16], w[3:0]};
			e.u = e.m && c && (w[3:0] == 4'hD || w[3:0] == 4'hF);
			e.d = e.m && c && !e.u;
			e.a = b + (rf[w[3:0]] << w[5:4]);
		end else if (w[31:24] == 8'hF9 && w[22:16] == 7'h1F && w[15:12] == 4'hF) begin
			e.m = 1;
			e.i = c;
			e.a = w[23] ? p + w[11:0] : p - w[11:0];
		end else if (w[15:12] == 4'hF && (w[31:20] == 12'hF99 || w[31:20] == 12'hF91 &&
			w[11:8] == 4'hC)) begin
			e.m = 1;
			e.i = c;
			e.a = w[23] ? b + w[11:0] : b - w[7:0];
		end
		return e;
	endfunction : model
	task automatic step(logic v, logic [31:0] w, logic c);
		phd_exp_t    e;
		logic [31:0] p;
		p = rnd();
		e = '{default: 0};
		@(posedge clock);
		instr_valid <= v;
		instr_word <= w;
		cond_pass <= c;
		pc_value <= p;
		if (v)
			e = model(w, c, p);
		q.push_back(e);
	endtask : step
	// Results land two cycles after the take
	always @(negedge clock) begin
		if (q.size() == 3) begin
			if (q[1].m)
				check({base_reg_field, offset_reg_field}, q[1].f);
			if (q[0].d || q[0].i)
				last = q[0].a;
			hints += q[0].d + q[0].i;
			check({data_prefetch_request, instr_prefetch_request}, {q[0].d, q[0].i});
			check({unpredictable_flag, literal_data_redirect}, {q[0].u, q[0].r});
			check(prefetch_addr, last);
			void'(q.pop_front());
		end
	end
	task automatic report_and_stop();
		check(hint_count, hints[15:0]);
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop
	initial begin
		logic [31:0] n;
		for (int k = 0; k < 16; k++)
			rf[k] = rnd();
		repeat (8) @(posedge clock);
		rstn <= 1;
		foreach (dir[k])
			step(1, dir[k], 1);
		repeat (500) begin
			n = rnd();
			case (n[30:28])
				0: step(n[27], {12'hF81, n[19:16], 10'h3C0, n[5:0]}, n[26]);
				1: step(n[27], {12'hF99, n[19:16], 4'hF, n[11:0]}, n[26]);
				2: step(n[27], {12'hF91, n[19:16], 8'hFC, n[7:0]}, n[26]);
				3: step(n[27], {8'hF9, n[23], 7'h1F, 4'hF, n[11:0]}, n[26]);
				default: step(n[27], n, n[26]);
			endcase
		end
		repeat (3) step(0, 0, 0);
		// Let the sink register the last hint before its count is read
		@(negedge clock);
		report_and_stop();
	end
	// A hang counts as a mismatch
	initial begin
		#100_000 err_count++;
		report_and_stop();
	end
endmodule : tb
